//--- tb.sv
// Self-checking testbench for the line format control block
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] A_DAT = {ulfc_pkg::IDX_DATA, 2'b00};
    localparam logic [11:0] A_IER = {ulfc_pkg::IDX_IER, 2'b00};
    localparam logic [11:0] A_LFC = {ulfc_pkg::IDX_LFC, 2'b00};
    localparam logic [11:0] A_ST = {ulfc_pkg::IDX_STATUS, 2'b00};
    localparam logic [7:0] DIV = 8'h04;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mon = 1;
    logic        pready, pslverr, rxd, txd, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, r;
    logic [7:0]  cfg = 0, d;
    logic [10:0] got;
    logic [8:0]  e, exp_q[$];
    int          fails = 0, cmp_count = 0, n;
    always #2 pclk = ~pclk;
    ulfc_uart DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd));
    ulfc_peer u_peer (.pclk(pclk), .presetn(presetn), .txd(txd), .mon(mon), .cfg(cfg),
        .bit_cyc({8'h00, DIV}), .rxd(rxd));
    // ==========================================================
    // Tasks and model
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, ex, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wlfc(input logic [7:0] v);
        apb(1'b1, A_LFC, v);
        cfg <= v;
    endtask : wlfc
    task automatic wait_st(input int b);
        n = 0;
        do begin
            apb(1'b0, A_ST, 8'h00);
            n++;
        end while (rd[b] !== 1'b1 && n < 400);
        check("status poll", n < 400, 1);
    endtask : wait_st
    function automatic logic [7:0] msk(input logic [7:0] c);
        return 8'hff >> (2'd3 - c[1:0]);
    endfunction : msk
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        fails++;
        stop_test;
    end
    // ==========================================================
    // Tests
    initial begin
        void'($urandom(19273));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_LFC, 8'h00);
        check("lfc reset", rd, 32'h0);
        apb(1'b0, A_ST, 8'h00);
        check("status reset", rd, 32'h0c);
        apb(1'b0, A_LFC + 12'h004, 8'h00);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b0, A_LFC + 12'h001, 8'h00);
        check("misaligned read", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, A_LFC + 12'h002, 8'hff);
        check("misaligned write", err, 1);
        apb(1'b0, A_LFC, 8'h00);
        check("lfc kept", rd, 32'h0);
        apb(1'b1, A_IER, 8'h5a);
        wlfc(8'h80);
        apb(1'b1, A_DAT, DIV);
        apb(1'b1, A_IER, 8'h00);
        apb(1'b0, A_DAT, 8'h00);
        check("divisor low", rd, {24'h0, DIV});
        wlfc(8'h00);
        apb(1'b0, A_IER, 8'h00);
        check("enable byte", rd, 32'h5a);
        $display("test registers done");
        for (int f = 0; f < 16; f++) begin
            wait_st(ulfc_pkg::ST_TX_IDLE);
            r = $urandom;
            wlfc({2'b00, r[1:0], f[3:0]});
            repeat (2) begin
                wait_st(ulfc_pkg::ST_THR_EMPTY);
                r = $urandom;
                d = r[7:0];
                apb(1'b1, A_DAT, d);
                exp_q.push_back({^(d & msk(cfg)) ^ !cfg[4] ^ cfg[5], d & msk(cfg)});
            end
            n = 0;
            while (u_peer.rx_q.size() < 2 && n < 3000) begin
                @(posedge pclk);
                n++;
            end
            check("tx count", u_peer.rx_q.size(), 2);
            repeat (2) begin
                got = u_peer.rx_q.pop_front();
                e = exp_q.pop_front();
                check("tx data", got[7:0], e[7:0]);
                check("tx parity", got[8], cfg[3] & e[8]);
                check("tx stop", got[9], 1);
            end
        end
        $display("test transmit done");
        wait_st(ulfc_pkg::ST_TX_IDLE);
        mon <= 1'b0;
        wlfc(8'h43);
        repeat (3 * DIV) @(posedge pclk);
        repeat (16) begin
            @(posedge pclk);
            check("break low", txd, 0);
        end
        wlfc(8'h03);
        repeat (4 * DIV) @(posedge pclk);
        check("break end", txd, 1);
        mon <= 1'b1;
        $display("test break done");
        for (int k = 0; k < 8; k++) begin
            r = $urandom;
            wlfc({3'b000, r[4], k[0], r[2:0]});
            @(posedge pclk);
            u_peer.send(r[15:8], r[5]);
            wait_st(ulfc_pkg::ST_RX_READY);
            check("rx parity flag", rd[1], k[0] & r[5]);
            apb(1'b0, A_DAT, 8'h00);
            check("rx data", rd, {24'h0, r[15:8] & msk(cfg)});
            apb(1'b0, A_ST, 8'h00);
            check("rx flags clear", rd[1:0], 0);
        end
        $display("test receive done");
        stop_test;
    end
endmodule : tb

//--- ulfc_peer.sv
// Remote serial peer: decodes txd frames, sends frames on rxd
`timescale 1ns/1ps
module ulfc_peer (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        txd,
    input wire logic        mon,
    input wire logic [7:0]  cfg,
    input wire logic [15:0] bit_cyc,
    output logic            rxd
);
    logic [10:0] rx_q[$];
    logic [7:0]  d;
    logic        p, ok;
    initial rxd = 1'b1;
    // ==========================================================
    // Decoder, samples at mid-bit
    always begin
        @(posedge pclk);
        if (mon && presetn && txd === 1'b0) begin
            repeat (bit_cyc / 2) @(posedge pclk);
            d = 8'h00;
            p = 1'b0;
            ok = 1'b1;
            for (int i = 0; i < int'(cfg[1:0]) + 5; i++) begin
                repeat (bit_cyc) @(posedge pclk);
                d[i] = txd;
            end
            if (cfg[3]) begin
                repeat (bit_cyc) @(posedge pclk);
                p = txd;
            end
            for (int s = 0; s <= int'(cfg[2]); s++) begin
                repeat (bit_cyc) @(posedge pclk);
                ok = ok & txd;
            end
            rx_q.push_back({ok, p, d});
        end
    end
    // ==========================================================
    // Sender, bad flips the parity bit
    task automatic send(input logic [7:0] v, input logic bad);
        logic [7:0] m;
        m = v & (8'hff >> (2'd3 - cfg[1:0]));
        rxd <= 1'b0;
        repeat (bit_cyc) @(posedge pclk);
        for (int i = 0; i < int'(cfg[1:0]) + 5; i++) begin
            rxd <= m[i];
            repeat (bit_cyc) @(posedge pclk);
        end
        if (cfg[3]) begin
            rxd <= ^m ^ !cfg[4] ^ bad;
            repeat (bit_cyc) @(posedge pclk);
        end
        rxd <= 1'b1;
        repeat (bit_cyc * 2) @(posedge pclk);
    endtask : send
endmodule : ulfc_peer

//--- ulfc_pkg.sv
// Constants, register map and field layouts of the UART line format control block
package ulfc_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_DATA   = 10'h0c0;
    localparam logic [9:0] IDX_IER    = 10'h0c1;
    localparam logic [9:0] IDX_LFC    = 10'h0c3;
    localparam logic [9:0] IDX_STATUS = 10'h0c5;
    localparam int         ADDR_W     = 12;

    // ==========================================================
    // Reset values and character length bounds
    localparam logic [7:0]  LFC_RESET  = 8'h00;
    localparam logic [7:0]  IER_RESET  = 8'h00;
    localparam logic [15:0] DIV_RESET  = 16'h0001;
    localparam logic [3:0]  CHAR_BASE  = 4'h5;
    localparam logic [3:0]  CHAR_MAX   = 4'h8;

    // ==========================================================
    // Status register bit positions
    localparam int ST_RX_READY   = 0;
    localparam int ST_PAR_ERR    = 1;
    localparam int ST_THR_EMPTY  = 2;
    localparam int ST_TX_IDLE    = 3;

    // ==========================================================
    // Line format control fields, bit 7 down to bit 0
    typedef struct packed {
        logic       divisor_bank_select;
        logic       send_break;
        logic       force_parity_error;
        logic       even_parity_select;
        logic       parity_enable;
        logic       two_stop;
        logic [1:0] char_len;
    } ulfc_lfc_type;

    // Serial sequencer states, Gray coded along the frame
    typedef enum logic [2:0] {
        SER_IDLE   = 3'h0,
        SER_START  = 3'h1,
        SER_DATA   = 3'h3,
        SER_PARITY = 3'h2,
        SER_STOP   = 3'h6
    } ulfc_ser_type;
endpackage : ulfc_pkg

//--- ulfc_props.sv
// Port checker for the line format control block
`timescale 1ns/1ps
module ulfc_props (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ulfc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        rxd,
    input wire logic                        txd
);
    // ==========================================================
    // Shadow registers
    logic [7:0]  lfc_q, lfc_d;
    logic [15:0] div_q, div_d;
    logic [16:0] brk_q, brk_d;
    logic        setup, wr;
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite && !pslverr;
    always_comb begin
        lfc_d = lfc_q;
        div_d = div_q;
        if (wr && paddr == {ulfc_pkg::IDX_LFC, 2'b00})
            lfc_d = pwdata[7:0];
        if (wr && lfc_q[7] && paddr == {ulfc_pkg::IDX_DATA, 2'b00})
            div_d[7:0] = pwdata[7:0];
        if (wr && lfc_q[7] && paddr == {ulfc_pkg::IDX_IER, 2'b00})
            div_d[15:8] = pwdata[7:0];
        // Slack of two covers the registered output and a zero divisor
        brk_d = (lfc_q[6] && txd) ? brk_q + 17'h1 : 17'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfc_q <= ulfc_pkg::LFC_RESET;
            div_q <= ulfc_pkg::DIV_RESET;
            brk_q <= 17'h0;
        end else begin
            lfc_q <= lfc_d;
            div_q <= div_d;
            brk_q <= brk_d;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_misaligned: assert property (setup && paddr[1:0] != 2'b00
        |=> pslverr && prdata == 32'h0) else $error("misaligned access not refused");
    a_lfc_readback: assert property (setup && !pwrite &&
        paddr == {ulfc_pkg::IDX_LFC, 2'b00} |=> !pslverr && prdata == {24'h0, lfc_q})
        else $error("line format readback wrong");
    a_div_readback: assert property (setup && !pwrite && lfc_q[7] &&
        paddr == {ulfc_pkg::IDX_DATA, 2'b00} |=> prdata == {24'h0, div_q[7:0]})
        else $error("divisor readback wrong");
    a_break_holds: assert property (lfc_q[6] && $past(lfc_q[6]) && !$past(txd) |-> !txd)
        else $error("txd left low level during break");
    a_break_reaches_low: assert property (brk_q <= {1'b0, div_q} + 17'h2)
        else $error("break not on line within a bit");
endmodule : ulfc_props

bind ulfc_uart ulfc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));

//--- ulfc_tick.sv
// Bit period divider with restart, one-cycle tick enable
`timescale 1ns/1ps
module ulfc_tick #(
    parameter int DIV_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] preset,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);
    logic [DIV_W-1:0] count_q;
    logic [DIV_W-1:0] count_d;
    logic [DIV_W-1:0] period;

    // Zero divisor behaves as one, so the line never stalls
    assign period = (divisor == '0) ? DIV_W'(1) : divisor;

    always_comb begin
        tick    = 1'b0;
        count_d = count_q;
        if (restart) begin
            count_d = preset;
        end else if (count_q == '0) begin
            tick    = 1'b1;
            count_d = period - DIV_W'(1);
        end else begin
            count_d = count_q - DIV_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule : ulfc_tick

//--- ulfc_uart.sv
// UART line format control: APB registers, framing transmitter and receiver
//
// Overview of operation
// RULE_01: Parity enable clear: no parity bit sent, none expected or checked.
// RULE_02: Parity enable set: parity bit computed and sent with each character.
// RULE_03: Parity enable set: receiver checks every character's parity bit.
// RULE_04: Low two format bits select 5, 6, 7 or 8 data bits.
// RULE_05: Format bit 2 selects one or two transmitted stop bits.
// RULE_06: Break drives line low from next bit boundary; data is ignored.
// RULE_07: Bank select steers data and enable addresses to divisor registers.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module ulfc_uart #(
    parameter int DIV_W = 16
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ulfc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        rxd,
    output logic                             txd
);
    // ==========================================================
    // Register state
    ulfc_pkg::ulfc_lfc_type lfc_q, lfc_d;
    logic [7:0]        ier_q, ier_d;
    logic [DIV_W-1:0]  div_q, div_d;
    logic [7:0]        thr_q, thr_d;
    logic              thr_full_q, thr_full_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pready_q, pready_d;
    logic              pslverr_q, pslverr_d;
    logic [7:0]        rx_data_q, rx_data_d;
    logic              rx_ready_q, rx_ready_d;
    logic              par_err_q, par_err_d;

    logic [9:0] idx;
    logic       hit_data, hit_ier, hit_lfc, hit_status, mapped;
    logic       setup, commit;
    logic [3:0] nbits;
    logic       tx_load, rx_done, rx_bad, tx_idle;
    logic [7:0] rx_word;

    assign idx        = paddr[ulfc_pkg::ADDR_W-1:2];
    assign hit_data   = (idx == ulfc_pkg::IDX_DATA);
    assign hit_ier    = (idx == ulfc_pkg::IDX_IER);
    assign hit_lfc    = (idx == ulfc_pkg::IDX_LFC);
    assign hit_status = (idx == ulfc_pkg::IDX_STATUS);
    assign mapped     = (paddr[1:0] == 2'h0) && (hit_data || hit_ier || hit_lfc || hit_status);
    assign setup      = psel && !penable;
    // Answer is staged in setup so all bus outputs come from flops
    assign commit     = psel && penable && pready_q && !pslverr_q;
    assign nbits      = ulfc_pkg::CHAR_BASE + {2'h0, lfc_q.char_len}; // RULE_04

    // ==========================================================
    // APB slave and registers
    always_comb begin
        lfc_d      = lfc_q;
        ier_d      = ier_q;
        div_d      = div_q;
        thr_d      = thr_q;
        thr_full_d = thr_full_q && !tx_load;
        rx_data_d  = rx_data_q;
        rx_ready_d = rx_ready_q;
        par_err_d  = par_err_q;
        prdata_d   = prdata_q;
        pready_d   = setup;
        pslverr_d  = setup && !mapped;
        if (setup) begin
            prdata_d = '0;
            // Refused accesses read back as zero
            if (!pwrite && mapped) begin
                if (hit_data && lfc_q.divisor_bank_select) begin // RULE_07
                    prdata_d[7:0] = div_q[7:0];
                end else if (hit_data) begin
                    prdata_d[7:0] = rx_data_q;
                end else if (hit_ier && lfc_q.divisor_bank_select) begin // RULE_07
                    prdata_d[7:0] = div_q[DIV_W-1:8];
                end else if (hit_ier) begin
                    prdata_d[7:0] = ier_q;
                end else if (hit_lfc) begin
                    prdata_d[7:0] = lfc_q;
                end else if (hit_status) begin
                    prdata_d[ulfc_pkg::ST_RX_READY]  = rx_ready_q;
                    prdata_d[ulfc_pkg::ST_PAR_ERR]   = par_err_q;
                    prdata_d[ulfc_pkg::ST_THR_EMPTY] = !thr_full_q;
                    prdata_d[ulfc_pkg::ST_TX_IDLE]   = !thr_full_q && tx_idle;
                end
            end
        end
        if (commit) begin
            if (pwrite) begin
                if (hit_data && lfc_q.divisor_bank_select) begin // RULE_07
                    div_d[7:0] = pwdata[7:0];
                end else if (hit_data) begin
                    thr_d      = pwdata[7:0];
                    thr_full_d = 1'b1;
                end else if (hit_ier && lfc_q.divisor_bank_select) begin // RULE_07
                    div_d[DIV_W-1:8] = pwdata[7:0];
                end else if (hit_ier) begin
                    ier_d = pwdata[7:0];
                end else if (hit_lfc) begin
                    lfc_d = pwdata[7:0];
                end
            end else if (hit_data && !lfc_q.divisor_bank_select) begin
                rx_ready_d = 1'b0;
                par_err_d  = 1'b0;
            end
        end
        // A frame completing during the clearing read still sets the flags
        if (rx_done) begin
            rx_data_d  = rx_word;
            rx_ready_d = 1'b1;
            par_err_d  = rx_bad;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfc_q      <= ulfc_pkg::LFC_RESET;
            ier_q      <= ulfc_pkg::IER_RESET;
            div_q      <= ulfc_pkg::DIV_RESET;
            thr_q      <= '0;
            thr_full_q <= 1'b0;
            rx_data_q  <= '0;
            rx_ready_q <= 1'b0;
            par_err_q  <= 1'b0;
            prdata_q   <= '0;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
        end else begin
            lfc_q      <= lfc_d;
            ier_q      <= ier_d;
            div_q      <= div_d;
            thr_q      <= thr_d;
            thr_full_q <= thr_full_d;
            rx_data_q  <= rx_data_d;
            rx_ready_q <= rx_ready_d;
            par_err_q  <= par_err_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Transmitter
    ulfc_pkg::ulfc_ser_type tx_st_q, tx_st_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic [3:0] tx_cnt_q, tx_cnt_d;
    logic       tx_par_q, tx_par_d;
    logic       tx_stop2_q, tx_stop2_d;
    logic       txd_q, txd_d;
    logic       tx_bit, tx_tick;

    ulfc_tick #(.DIV_W(DIV_W)) u_tx_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (1'b0),
        .preset  ('0),
        .divisor (div_q),
        .tick    (tx_tick)
    );

    assign tx_idle = (tx_st_q == ulfc_pkg::SER_IDLE);

    always_comb begin
        tx_st_d    = tx_st_q;
        tx_sh_d    = tx_sh_q;
        tx_cnt_d   = tx_cnt_q;
        tx_par_d   = tx_par_q;
        tx_stop2_d = tx_stop2_q;
        tx_bit     = 1'b1;
        tx_load    = 1'b0;
        txd_d      = txd_q;
        if (tx_tick) begin
            case (tx_st_q)
                ulfc_pkg::SER_START: begin
                    tx_bit   = tx_sh_q[0];
                    tx_par_d = tx_sh_q[0];
                    tx_sh_d  = {1'b0, tx_sh_q[7:1]};
                    tx_cnt_d = 4'h1;
                    tx_st_d  = ulfc_pkg::SER_DATA;
                end
                ulfc_pkg::SER_DATA: begin
                    if (tx_cnt_q == nbits) begin // RULE_04
                        if (lfc_q.parity_enable) begin // RULE_02
                            tx_bit  = tx_par_q ^ !lfc_q.even_parity_select
                                      ^ lfc_q.force_parity_error;
                            tx_st_d = ulfc_pkg::SER_PARITY;
                        end else begin // RULE_01
                            tx_stop2_d = lfc_q.two_stop; // RULE_05
                            tx_st_d    = ulfc_pkg::SER_STOP;
                        end
                    end else begin
                        tx_bit   = tx_sh_q[0];
                        tx_par_d = tx_par_q ^ tx_sh_q[0];
                        tx_sh_d  = {1'b0, tx_sh_q[7:1]};
                        tx_cnt_d = tx_cnt_q + 4'h1;
                    end
                end
                ulfc_pkg::SER_PARITY: begin
                    tx_stop2_d = lfc_q.two_stop; // RULE_05
                    tx_st_d    = ulfc_pkg::SER_STOP;
                end
                ulfc_pkg::SER_STOP, ulfc_pkg::SER_IDLE: begin
                    if (tx_st_q == ulfc_pkg::SER_STOP && tx_stop2_q) begin
                        tx_stop2_d = 1'b0; // RULE_05
                    end else if (thr_full_q) begin
                        tx_bit  = 1'b0;
                        tx_load = 1'b1;
                        tx_sh_d = thr_q;
                        tx_st_d = ulfc_pkg::SER_START;
                    end else begin
                        tx_st_d = ulfc_pkg::SER_IDLE;
                    end
                end
                default: begin
                    tx_st_d = ulfc_pkg::SER_IDLE;
                end
            endcase
            // Frame keeps running under break so timing resumes cleanly
            txd_d = lfc_q.send_break ? 1'b0 : tx_bit; // RULE_06
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q    <= ulfc_pkg::SER_IDLE;
            tx_sh_q    <= '0;
            tx_cnt_q   <= '0;
            tx_par_q   <= 1'b0;
            tx_stop2_q <= 1'b0;
            txd_q      <= 1'b1;
        end else begin
            tx_st_q    <= tx_st_d;
            tx_sh_q    <= tx_sh_d;
            tx_cnt_q   <= tx_cnt_d;
            tx_par_q   <= tx_par_d;
            tx_stop2_q <= tx_stop2_d;
            txd_q      <= txd_d;
        end
    end

    assign txd = txd_q;

    // ==========================================================
    // Receiver, sampling at mid-bit
    ulfc_pkg::ulfc_ser_type rx_st_q, rx_st_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [3:0] rx_cnt_q, rx_cnt_d;
    logic       rx_par_q, rx_par_d;
    logic       rx_perr_q, rx_perr_d;
    logic       rx_tick, rx_start;

    assign rx_start = (rx_st_q == ulfc_pkg::SER_IDLE) && !rxd;

    ulfc_tick #(.DIV_W(DIV_W)) u_rx_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (rx_start),
        .preset  (div_q >> 1),
        .divisor (div_q),
        .tick    (rx_tick)
    );

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_sh_d   = rx_sh_q;
        rx_cnt_d  = rx_cnt_q;
        rx_par_d  = rx_par_q;
        rx_perr_d = rx_perr_q;
        rx_done   = 1'b0;
        // Short characters arrive at the top and are shifted down
        rx_word   = rx_sh_q >> (ulfc_pkg::CHAR_MAX - nbits);
        rx_bad    = rx_perr_q;
        if (rx_start) begin
            rx_st_d = ulfc_pkg::SER_START;
        end else if (rx_tick) begin
            case (rx_st_q)
                ulfc_pkg::SER_START: begin
                    rx_cnt_d  = '0;
                    rx_par_d  = 1'b0;
                    rx_perr_d = 1'b0;
                    // A glitch shorter than half a bit is dropped
                    rx_st_d   = rxd ? ulfc_pkg::SER_IDLE : ulfc_pkg::SER_DATA;
                end
                ulfc_pkg::SER_DATA: begin
                    rx_sh_d  = {rxd, rx_sh_q[7:1]};
                    rx_par_d = rx_par_q ^ rxd;
                    rx_cnt_d = rx_cnt_q + 4'h1;
                    if (rx_cnt_q + 4'h1 == nbits) begin // RULE_04
                        rx_st_d = lfc_q.parity_enable ? ulfc_pkg::SER_PARITY // RULE_03
                                                      : ulfc_pkg::SER_STOP; // RULE_01
                    end
                end
                ulfc_pkg::SER_PARITY: begin
                    // Even mode wants an even total, odd mode an odd one
                    rx_perr_d = (rx_par_q ^ rxd) == lfc_q.even_parity_select; // RULE_03
                    rx_st_d   = ulfc_pkg::SER_STOP;
                end
                ulfc_pkg::SER_STOP: begin
                    rx_done = 1'b1;
                    rx_st_d = ulfc_pkg::SER_IDLE;
                end
                default: begin
                    rx_st_d = ulfc_pkg::SER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q   <= ulfc_pkg::SER_IDLE;
            rx_sh_q   <= '0;
            rx_cnt_q  <= '0;
            rx_par_q  <= 1'b0;
            rx_perr_q <= 1'b0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_sh_q   <= rx_sh_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_par_q  <= rx_par_d;
            rx_perr_q <= rx_perr_d;
        end
    end
endmodule : ulfc_uart
